/* File: verilog/dcr_pkg.sv */
package dcr_pkg;

	// ****************************************************************
	// Register addresses
	// ****************************************************************
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h01;
	localparam logic [6:0] ADDR_CLK_RX     = 7'h03;
	localparam logic [6:0] ADDR_PORT_CTRL  = 7'h04;
	localparam logic [6:0] ADDR_GAIN_TRIM  = 7'h09;
	localparam logic [6:0] ADDR_TEST_MUX   = 7'h18;
	localparam logic [6:0] ADDR_TEMP_SENSE = 7'h19;
	localparam logic [6:0] ADDR_PGEN_CTRL  = 7'h1E;
	localparam logic [6:0] ADDR_PGEN_WORD  = 7'h1F;

	// ****************************************************************
	// Field positions, masks and reset values
	// ****************************************************************
	localparam int SOFT_RESET_BIT   = 0;
	localparam int CLK_RX_ON_BIT    = 0;
	localparam int CLK_QUAD_BIT     = 2;
	localparam int PORT_A_ON_BIT    = 0;
	localparam int PORT_B_ON_BIT    = 1;
	localparam int PORT_SINGLE_BIT  = 2;
	localparam int DATA_ON_BIT      = 3;
	localparam int MUX_SELECT_BIT   = 0;
	localparam int MUX_ADDR_LSB     = 1;
	localparam int MUX_ADDR_MSB     = 5;
	localparam int MUX_ON_BIT       = 6;
	localparam int TEMP_ON_BIT      = 0;
	localparam int TEMP_SELECT_BIT  = 1;
	localparam int PGEN_ON_BIT      = 0;
	localparam int GAIN_MSB         = 5;

	localparam logic [7:0] MASK_CLK_RX     = 8'h05;
	localparam logic [7:0] MASK_PORT_CTRL  = 8'h0F;
	localparam logic [7:0] MASK_GAIN_TRIM  = 8'h3F;
	localparam logic [7:0] MASK_TEST_MUX   = 8'h7F;
	localparam logic [7:0] MASK_TEMP_SENSE = 8'h03;
	localparam logic [7:0] MASK_PGEN_CTRL  = 8'h01;
	localparam logic [7:0] MASK_PGEN_WORD  = 8'hFF;

	localparam logic [7:0]  REG_RESET  = 8'h00;
	localparam logic [7:0]  READ_ZERO  = 8'h00;
	localparam logic [15:0] MID_SCALE  = 16'h8000;
	localparam int          DAC_WIDTH  = 16;

	// ****************************************************************
	// Serial frame layout
	// ****************************************************************
	localparam logic [3:0] CMD_LAST_BIT   = 4'h7;
	localparam logic [3:0] FRAME_LAST_BIT = 4'hF;
	localparam logic [3:0] FIRST_DATA_BIT = 4'h8;
	localparam int         READ_FLAG_POS  = 6;

	typedef enum logic [1:0] {
		DCR_IDLE = 2'b00,
		DCR_CMD  = 2'b01,
		DCR_DATA = 2'b11,
		DCR_DONE = 2'b10
	} dcr_frame_state_t;

endpackage

/* File: verilog/dcr_reg_if.sv */
`timescale 1ns/1ps
interface dcr_reg_if;
	logic       wr_stb;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport frame (output wr_stb, output addr, output wdata, input rdata);
	modport bank  (input wr_stb, input addr, input wdata, output rdata);
endinterface

/* File: verilog/dcr_spi_slave.sv */
`timescale 1ns/1ps
module dcr_spi_slave
	import dcr_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   reset_n,
	input  wire logic   spi_sck,
	input  wire logic   spi_cs_n,
	input  wire logic   spi_sdi,
	output logic        spi_sdo,
	output logic        spi_sdo_oe,
	dcr_reg_if.frame    regs
);

	// ****************************************************************
	// Edge detection on the serial clock
	// ****************************************************************
	// The serial pins are slow against clk_sys, so edges are found by sampling.
	logic             sck_prev;
	dcr_frame_state_t state;
	logic [3:0]       bit_cnt;
	logic [7:0]       shift_in;
	logic [7:0]       shift_out;
	logic             is_read;

	wire sck_rise   = spi_sck & ~sck_prev & ~spi_cs_n;
	wire sck_fall   = ~spi_sck & sck_prev & ~spi_cs_n;
	wire in_frame   = (state == DCR_CMD) || (state == DCR_DATA);
	wire cmd_end    = sck_rise && (state == DCR_CMD) && (bit_cnt == CMD_LAST_BIT);
	wire frame_end  = sck_rise && (state == DCR_DATA) && (bit_cnt == FRAME_LAST_BIT);
	wire load_read  = sck_fall && (state == DCR_DATA) && (bit_cnt == FIRST_DATA_BIT);

	// ****************************************************************
	// Frame sequencer
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sck_prev    <= 1'b0;
			state       <= DCR_IDLE;
			bit_cnt     <= 4'h0;
			shift_in    <= 8'h00;
			is_read     <= 1'b0;
			regs.addr   <= 7'h00;
			regs.wdata  <= 8'h00;
			regs.wr_stb <= 1'b0;
		end else begin
			sck_prev    <= spi_sck;
			regs.wr_stb <= frame_end && !is_read;
			if (spi_cs_n) begin
				state   <= DCR_IDLE;
				bit_cnt <= 4'h0;
			end else begin
				if (state == DCR_IDLE)
					state <= DCR_CMD;
				if (sck_rise && in_frame) begin
					shift_in <= {shift_in[6:0], spi_sdi};
					bit_cnt  <= bit_cnt + 4'h1;
				end
				if (cmd_end) begin
					is_read   <= shift_in[READ_FLAG_POS];
					regs.addr <= {shift_in[5:0], spi_sdi};
					state     <= DCR_DATA;
				end
				if (frame_end) begin
					regs.wdata <= {shift_in[6:0], spi_sdi};
					state      <= DCR_DONE;
				end
			end
		end
	end

	// ****************************************************************
	// Read-back shifter
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			shift_out  <= 8'h00;
			spi_sdo_oe <= 1'b0;
		end else begin
			spi_sdo_oe <= is_read && (state == DCR_DATA) && !spi_cs_n;
			if (load_read)
				shift_out <= regs.rdata;
			else if (sck_fall && (state == DCR_DATA))
				shift_out <= {shift_out[6:0], 1'b0};
		end
	end

	assign spi_sdo = shift_out[7];

endmodule // dcr_spi_slave

/* File: verilog/dcr_config_regs.sv */
`timescale 1ns/1ps
module dcr_config_regs
	import dcr_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 reset_n,
	input  wire logic                 spi_sck,
	input  wire logic                 spi_cs_n,
	input  wire logic                 spi_sdi,
	output logic                      spi_sdo,
	output logic                      spi_sdo_oe,
	input  wire logic                 sample_clock_in,
	output logic                      divided_clock_out,
	input  wire logic [DAC_WIDTH-1:0] port_a_data,
	input  wire logic [DAC_WIDTH-1:0] port_b_data,
	output logic [DAC_WIDTH-1:0]      dac_code,
	output logic [5:0]                gain_trim,
	output logic                      test_mux_select,
	output logic [4:0]                test_mux_addr,
	output logic                      test_mux_on,
	output logic                      temp_diode_on,
	output logic                      temp_sense_select,
	output logic                      pattern_gen_on,
	output logic [7:0]                pattern_word,
	output logic                      data_clock_rx_on,
	output logic                      data_clock_quadrature,
	output logic                      port_a_rx_on,
	output logic                      port_b_rx_on,
	output logic                      port_mode_single,
	output logic                      output_data_on
);

	// ****************************************************************
	// Serial port
	// ****************************************************************
	dcr_reg_if bus ();

	dcr_spi_slave u_spi (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.spi_sck    (spi_sck),
		.spi_cs_n   (spi_cs_n),
		.spi_sdi    (spi_sdi),
		.spi_sdo    (spi_sdo),
		.spi_sdo_oe (spi_sdo_oe),
		.regs       (bus)
	);

	// ****************************************************************
	// Register decode
	// ****************************************************************
	logic [7:0] clk_rx_ctrl;
	logic [7:0] port_ctrl;
	logic [7:0] gain_trim_reg;
	logic [7:0] test_mux_ctrl;
	logic [7:0] temp_sense_ctrl;
	logic [7:0] pattern_gen_ctrl;
	logic [7:0] pattern_gen_word;

	wire soft_reset = bus.wr_stb && (bus.addr == ADDR_SOFT_RESET) && bus.wdata[SOFT_RESET_BIT];
	wire wr_clk_rx  = bus.wr_stb && (bus.addr == ADDR_CLK_RX);
	wire wr_port    = bus.wr_stb && (bus.addr == ADDR_PORT_CTRL);
	wire wr_gain    = bus.wr_stb && (bus.addr == ADDR_GAIN_TRIM);
	wire wr_mux     = bus.wr_stb && (bus.addr == ADDR_TEST_MUX);
	wire wr_temp    = bus.wr_stb && (bus.addr == ADDR_TEMP_SENSE);
	wire wr_pg_ctrl = bus.wr_stb && (bus.addr == ADDR_PGEN_CTRL);
	wire wr_pg_word = bus.wr_stb && (bus.addr == ADDR_PGEN_WORD);

	// Unmapped addresses and the self-clearing reset location read as zero.
	wire [7:0] rd_mux =
		(bus.addr == ADDR_CLK_RX)     ? clk_rx_ctrl      :
		(bus.addr == ADDR_PORT_CTRL)  ? port_ctrl        :
		(bus.addr == ADDR_GAIN_TRIM)  ? gain_trim_reg    :
		(bus.addr == ADDR_TEST_MUX)   ? test_mux_ctrl    :
		(bus.addr == ADDR_TEMP_SENSE) ? temp_sense_ctrl  :
		(bus.addr == ADDR_PGEN_CTRL)  ? pattern_gen_ctrl :
		(bus.addr == ADDR_PGEN_WORD)  ? pattern_gen_word : READ_ZERO;
	assign bus.rdata = rd_mux;

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Masking at write time keeps reserved bits zero for both storage and read-back.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			clk_rx_ctrl      <= REG_RESET;
			port_ctrl        <= REG_RESET;
			gain_trim_reg    <= REG_RESET;
			test_mux_ctrl    <= REG_RESET;
			temp_sense_ctrl  <= REG_RESET;
			pattern_gen_ctrl <= REG_RESET;
			pattern_gen_word <= REG_RESET;
		end else if (soft_reset) begin
			clk_rx_ctrl      <= REG_RESET;
			port_ctrl        <= REG_RESET;
			gain_trim_reg    <= REG_RESET;
			test_mux_ctrl    <= REG_RESET;
			temp_sense_ctrl  <= REG_RESET;
			pattern_gen_ctrl <= REG_RESET;
			pattern_gen_word <= REG_RESET;
		end else begin
			if (wr_clk_rx)  clk_rx_ctrl      <= bus.wdata & MASK_CLK_RX;
			if (wr_port)    port_ctrl        <= bus.wdata & MASK_PORT_CTRL;
			if (wr_gain)    gain_trim_reg    <= bus.wdata & MASK_GAIN_TRIM;
			if (wr_mux)     test_mux_ctrl    <= bus.wdata & MASK_TEST_MUX;
			if (wr_temp)    temp_sense_ctrl  <= bus.wdata & MASK_TEMP_SENSE;
			if (wr_pg_ctrl) pattern_gen_ctrl <= bus.wdata & MASK_PGEN_CTRL;
			if (wr_pg_word) pattern_gen_word <= bus.wdata & MASK_PGEN_WORD;
		end
	end

	assign gain_trim             = gain_trim_reg[GAIN_MSB:0];
	assign test_mux_select       = test_mux_ctrl[MUX_SELECT_BIT];
	assign test_mux_addr         = test_mux_ctrl[MUX_ADDR_MSB:MUX_ADDR_LSB];
	assign test_mux_on           = test_mux_ctrl[MUX_ON_BIT];
	assign temp_diode_on         = temp_sense_ctrl[TEMP_ON_BIT];
	assign temp_sense_select     = temp_sense_ctrl[TEMP_SELECT_BIT];
	assign pattern_gen_on        = pattern_gen_ctrl[PGEN_ON_BIT];
	assign pattern_word          = pattern_gen_word;
	assign data_clock_rx_on      = clk_rx_ctrl[CLK_RX_ON_BIT];
	assign data_clock_quadrature = clk_rx_ctrl[CLK_QUAD_BIT];
	assign port_a_rx_on          = port_ctrl[PORT_A_ON_BIT];
	assign port_b_rx_on          = port_ctrl[PORT_B_ON_BIT];
	assign port_mode_single      = port_ctrl[PORT_SINGLE_BIT];
	assign output_data_on        = port_ctrl[DATA_ON_BIT];

	// ****************************************************************
	// Divided clock output
	// ****************************************************************
	// Toggling on every second sample-clock rise gives a quarter-rate output.
	logic sample_prev;
	logic div_phase;
	wire  sample_rise = sample_clock_in & ~sample_prev;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sample_prev       <= 1'b0;
			div_phase         <= 1'b0;
			divided_clock_out <= 1'b0;
		end else begin
			sample_prev <= sample_clock_in;
			if (sample_rise) begin
				div_phase <= ~div_phase;
				if (div_phase)
					divided_clock_out <= ~divided_clock_out;
			end
		end
	end

	// ****************************************************************
	// Converter data path
	// ****************************************************************
	// Dual-port mode alternates port A then port B; the host keeps the rate matched.
	logic port_sel_b;
	wire [DAC_WIDTH-1:0] live_code = port_mode_single ? port_b_data :
		(port_sel_b ? port_b_data : port_a_data);
	wire [DAC_WIDTH-1:0] next_code = !output_data_on ? MID_SCALE :
		(pattern_gen_on ? {pattern_word, pattern_word} : live_code);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			port_sel_b <= 1'b0;
			dac_code   <= MID_SCALE;
		end else begin
			port_sel_b <= output_data_on && !port_mode_single && !port_sel_b;
			dac_code   <= next_code;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_gain_write;
		@(posedge clk_sys) disable iff (!reset_n)
		wr_gain |=> (gain_trim == $past(bus.wdata[5:0])) && (gain_trim_reg[7:6] == 2'h0);
	endproperty
	a_gain_write: assert property (p_gain_write) else $error("gain trim write mismatch");

	property p_mux_write;
		@(posedge clk_sys) disable iff (!reset_n)
		wr_mux |=> (test_mux_addr == $past(bus.wdata[5:1])) && (test_mux_select == $past(bus.wdata[0]));
	endproperty
	a_mux_write: assert property (p_mux_write) else $error("test mux fields mismatch");

	property p_temp_write;
		@(posedge clk_sys) disable iff (!reset_n)
		wr_temp |=> (temp_sense_select == $past(bus.wdata[1])) && (temp_diode_on == $past(bus.wdata[0]));
	endproperty
	a_temp_write: assert property (p_temp_write) else $error("temperature control mismatch");

	property p_pattern_out;
		@(posedge clk_sys) disable iff (!reset_n)
		(output_data_on && pattern_gen_on) |=> (dac_code == {$past(pattern_word), $past(pattern_word)});
	endproperty
	a_pattern_out: assert property (p_pattern_out) else $error("pattern word not on output");

	property p_soft_reset;
		@(posedge clk_sys) disable iff (!reset_n)
		soft_reset |=> (gain_trim == 6'h00) && !port_a_rx_on && !output_data_on && (pattern_word == 8'h00);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

	property p_mid_scale;
		@(posedge clk_sys) disable iff (!reset_n)
		!output_data_on |=> (dac_code == MID_SCALE);
	endproperty
	a_mid_scale: assert property (p_mid_scale) else $error("output not mid-scale");

	property p_single_port;
		@(posedge clk_sys) disable iff (!reset_n)
		(output_data_on && port_mode_single && !pattern_gen_on) |=> (dac_code == $past(port_b_data));
	endproperty
	a_single_port: assert property (p_single_port) else $error("single port not from port B");

	property p_clk_rx;
		@(posedge clk_sys) disable iff (!reset_n)
		wr_clk_rx |=> (data_clock_quadrature == $past(bus.wdata[2])) && (data_clock_rx_on == $past(bus.wdata[0]));
	endproperty
	a_clk_rx: assert property (p_clk_rx) else $error("clock receiver control mismatch");

	property p_port_rx;
		@(posedge clk_sys) disable iff (!reset_n)
		wr_port |=> (port_a_rx_on == $past(bus.wdata[0])) && (port_b_rx_on == $past(bus.wdata[1]));
	endproperty
	a_port_rx: assert property (p_port_rx) else $error("port receiver enables mismatch");

	property p_reserved_read;
		@(posedge clk_sys) disable iff (!reset_n)
		((bus.addr < ADDR_CLK_RX) || (bus.addr > ADDR_PGEN_WORD)) |-> (bus.rdata == 8'h00);
	endproperty
	a_reserved_read: assert property (p_reserved_read) else $error("reserved address read nonzero");

	property p_divider;
		@(posedge clk_sys) disable iff (!reset_n)
		$changed(divided_clock_out) |-> $past(sample_rise) && !div_phase;
	endproperty
	a_divider: assert property (p_divider) else $error("divided clock toggled off schedule");

endmodule // dcr_config_regs

/* File: verification/dcr_host_model.sv */
`timescale 1ns/1ps
module dcr_host_model
	import dcr_pkg::*;
(
	input  wire logic clk_sys,
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_sdi,
	input  wire logic spi_sdo,
	input  wire logic spi_sdo_oe
);
	// Each serial phase is twice the minimum so a slow synchronizer still sees every edge.
	localparam int PHASE = 4;
	logic oe_match;

	initial begin
		spi_sck  = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi  = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// ****************************************************************
	// Frame transfer, MSB first; a short count ends the frame early
	// ****************************************************************
	task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata, input int nbits,
			output logic [7:0] rdata);
		logic [15:0] frame;
		frame = {rd, addr, wdata};
		rdata = 8'h00;
		oe_match = 1'b1;
		@(posedge clk_sys);
		spi_cs_n <= 1'b0;
		for (int i = 15; i >= 16 - nbits; i--) begin
			spi_sdi <= frame[i];
			wait_clk(PHASE);
			if (i < 8) begin
				rdata[i] = spi_sdo;
				// The drive enable must follow the frame's direction through the whole data phase.
				if (spi_sdo_oe !== rd)
					oe_match = 1'b0;
			end
			spi_sck <= 1'b1;
			wait_clk(PHASE);
			spi_sck <= 1'b0;
		end
		wait_clk(PHASE);
		spi_cs_n <= 1'b1;
		// A released data line must not keep its last level, or a stale bit could pass for a good one.
		spi_sdi  <= ~spi_sdi;
		wait_clk(PHASE);
	endtask
endmodule // dcr_host_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench
	import dcr_pkg::*;
;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic [7:0] rexp;
	} dcr_row_t;

	logic        clk_sys, reset_n, spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
	logic        sample_clock_in, divided_clock_out, sample_en;
	logic [1:0]  sample_ph;
	logic [15:0] port_a_data, port_b_data, dac_code;
	logic [5:0]  gain_trim;
	logic [4:0]  test_mux_addr;
	logic [7:0]  pattern_word;
	logic        test_mux_select, test_mux_on, temp_diode_on, temp_sense_select, pattern_gen_on;
	logic        data_clock_rx_on, data_clock_quadrature, port_a_rx_on, port_b_rx_on;
	logic        port_mode_single, output_data_on;
	wire logic [29:0] cfg_seen;
	logic [7:0]  sh [0:127];
	dcr_row_t    rows [0:13];
	int          errors, n_compared;
	logic        host_single = 1'b0, dck_ph = 1'b0, data_clock_in = 1'b0, sample_q = 1'b0;

	assign cfg_seen = {gain_trim, test_mux_on, test_mux_addr, test_mux_select, temp_sense_select, temp_diode_on,
		pattern_gen_on, pattern_word, data_clock_quadrature, data_clock_rx_on, output_data_on, port_mode_single,
		port_b_rx_on, port_a_rx_on};

	dcr_config_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sample_clock_in(sample_clock_in),
		.divided_clock_out(divided_clock_out), .port_a_data(port_a_data), .port_b_data(port_b_data),
		.dac_code(dac_code), .gain_trim(gain_trim), .test_mux_select(test_mux_select),
		.test_mux_addr(test_mux_addr), .test_mux_on(test_mux_on), .temp_diode_on(temp_diode_on),
		.temp_sense_select(temp_sense_select), .pattern_gen_on(pattern_gen_on), .pattern_word(pattern_word),
		.data_clock_rx_on(data_clock_rx_on), .data_clock_quadrature(data_clock_quadrature),
		.port_a_rx_on(port_a_rx_on), .port_b_rx_on(port_b_rx_on), .port_mode_single(port_mode_single),
		.output_data_on(output_data_on));

	dcr_host_model host_u (.clk_sys(clk_sys), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

	initial clk_sys = 1'b0;
	always #12.5 clk_sys = ~clk_sys;

	// Sample clock at a quarter of clk_sys: slow enough that every rise is seen.
	always @(posedge clk_sys) begin
		sample_ph       <= sample_en ? sample_ph + 2'h1 : 2'h0;
		sample_clock_in <= sample_en & sample_ph[1];
	end

	// Host data clock: every sample rise in single-port mode, every second one in dual-port mode.
	always @(posedge clk_sys) begin
		sample_q <= sample_clock_in;
		if (sample_clock_in && !sample_q) begin
			dck_ph <= ~dck_ph;
			if (dck_ph || host_single)
				data_clock_in <= ~data_clock_in;
		end
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] unused;
		host_u.xfer(1'b0, a, d, 16, unused);
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		host_u.xfer(1'b1, a, 8'h00, 16, q);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic wait_change(input logic sel, output int n);
		logic prev;
		prev = sel ? data_clock_in : divided_clock_out;
		n    = 0;
		while ((sel ? data_clock_in : divided_clock_out) === prev && n < 40) begin
			settle(1);
			n++;
		end
	endtask

	function automatic logic [29:0] exp_cfg();
		return {sh[7'h09][5:0], sh[7'h18][6:0], sh[7'h19][1:0], sh[7'h1E][0], sh[7'h1F], sh[7'h03][2],
			sh[7'h03][0], sh[7'h04][3:0]};
	endfunction

	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// The longest stretch is two one-millisecond waits; this leaves some slack above them.
	initial begin
		repeat (98000) @(posedge clk_sys);
		errors++;
		print_verdict();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [7:0]  q;
		logic [15:0] c1, c2;
		logic [7:0]  seq [0:1][0:2];
		int          n;
		errors = 0;
		n_compared = 0;
		reset_n = 1'b0;
		sample_en = 1'b0;
		port_a_data = 16'h1234;
		port_b_data = 16'hABCD;
		seq = '{'{8'h01, 8'h03, 8'h0B}, '{8'h05, 8'h06, 8'h0E}};
		foreach (sh[i])
			sh[i] = 8'h00;
		rows = '{'{7'h09, 8'hFF, 8'h3F}, '{7'h09, 8'h2A, 8'h2A}, '{7'h18, 8'hFF, 8'h7F},
			'{7'h18, 8'h3E, 8'h3E},
			'{7'h19, 8'hFF, 8'h03}, '{7'h19, 8'h02, 8'h02}, '{7'h1E, 8'hFF, 8'h01}, '{7'h1F, 8'hA5, 8'hA5},
			'{7'h03, 8'hFF, 8'h05}, '{7'h04, 8'hF7, 8'h07}, '{7'h0A, 8'h55, 8'h00}, '{7'h1D, 8'hFF, 8'h00},
			'{7'h7F, 8'hFF, 8'h00}, '{7'h01, 8'hFE, 8'h00}};
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		settle(2);
		check(cfg_seen, 30'h0);
		check(dac_code, 16'h8000);
		for (int i = 0; i < 14; i++) begin
			wr(rows[i].addr, rows[i].wdata);
			check(host_u.oe_match, 1'b1);
			rd(rows[i].addr, q);
			check(host_u.oe_match, 1'b1);
			check(q, rows[i].rexp);
			sh[rows[i].addr] = rows[i].rexp;
			check(cfg_seen, exp_cfg());
		end
		$display("test register rows done");
		host_u.xfer(1'b0, 7'h09, 8'h11, 10, q);
		rd(7'h09, q);
		check(q, 8'h2A);
		$display("test aborted frame done");
		settle(2);
		check(dac_code, 16'h8000);
		wr(7'h04, 8'h0F);
		settle(2);
		check(dac_code, 16'hA5A5);
		wr(7'h1E, 8'h00);
		settle(2);
		check(dac_code, 16'hABCD);
		wr(7'h04, 8'h0B);
		settle(2);
		c1 = dac_code;
		settle(1);
		c2 = dac_code;
		check(c1 ^ c2, 16'h1234 ^ 16'hABCD);
		check(c1 + c2, 32'h1234 + 32'hABCD);
		$display("test data path done");
		sample_en <= 1'b1;
		wait_change(1'b0, n);
		wait_change(1'b0, n);
		check(n, 8);
		sample_en <= 1'b0;
		$display("test divided clock done");
		for (int m = 0; m < 2; m++) begin
			wr(7'h01, 8'h01);
			settle(1);
			check(cfg_seen, 30'h0);
			check(dac_code, 16'h8000);
			host_single <= (m == 1);
			sample_en <= 1'b1;
			port_a_data <= 16'h0000;
			port_b_data <= 16'h0000;
			wr(7'h03, seq[m][0]);
			wr(7'h04, seq[m][1]);
			check(cfg_seen, {24'h0, seq[m][0][2], seq[m][0][0], seq[m][1][3:0]});
			repeat (40000) @(posedge clk_sys);
			wait_change(1'b1, n);
			wait_change(1'b1, n);
			check(n, (m == 1) ? 4 : 8);
			wait_change(1'b0, n);
			wait_change(1'b0, n);
			check(n, 8);
			wr(7'h04, seq[m][2]);
			settle(2);
			check(cfg_seen, {24'h0, seq[m][0][2], seq[m][0][0], seq[m][2][3:0]});
			check(dac_code, 16'h0000);
		end
		sample_en <= 1'b0;
		$display("test start-up sequence done");
		reset_n <= 1'b0;
		settle(6);
		reset_n <= 1'b1;
		settle(2);
		check(cfg_seen, 30'h0);
		check(dac_code, 16'h8000);
		check(divided_clock_out, 1'b0);
		rd(7'h04, q);
		check(q, 8'h00);
		$display("test second reset done");
		print_verdict();
	end
endmodule // testbench
